// ---- testbench.sv ----
`timescale 1ns/1ps
`include "tks_defs.svh"
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  a;   // byte offset
    logic [31:0] wd;  // written value
    logic [31:0] rd;  // expected readback
    logic [11:0] t;   // expected touch pins
  } tks_row_s;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT, HRESP, IRQ;
  logic [2:0]  ref_tick, key_tick, ref_run, key_run;
  logic [11:0] pad_out, pad_oe, gpio_in, touch_in;
  logic [31:0] rd;
  int          failures = 0, comparisons = 0, cycles = 0;
  int          len_fast, len_slow;
  // bit 6 of a control byte reads zero; last rows free modules 1, 2 and then 0
  tks_row_s    rows [9] = '{
    '{`TKS_OFS_MC1_0, 32'hff, 32'hbf, 12'h00f},
    '{`TKS_OFS_MC1_1, 32'h5a, 32'h1a, 12'h0af},
    '{`TKS_OFS_MC1_2, 32'h43, 32'h03, 12'h3af},
    '{`TKS_OFS_PRESET, 32'h00fefefe, 32'h00fefefe, 12'h3af},
    '{`TKS_OFS_IMASK, 32'h7, 32'h7, 12'h3af},
    '{8'h3c, 32'hffffffff, 32'h0, 12'h3af},
    '{`TKS_OFS_MC1_1, 32'h0, 32'h0, 12'h30f},
    '{`TKS_OFS_MC1_2, 32'h0, 32'h0, 12'h00f},
    '{`TKS_OFS_MC1_0, 32'h0, 32'h0, 12'h000}};

  always #2.5 CLK = ~CLK;

  tks_touch_scanner i_tks_touch_scanner (
    .CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .REF_OSC_TICK(ref_tick), .KEY_OSC_TICK(key_tick), .REF_OSC_RUN(ref_run),
    .KEY_OSC_RUN(key_run), .PAD_IN(12'hfff), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
    .GPIO_OUT(12'ha5a), .GPIO_OE(12'hfff), .GPIO_IN(gpio_in),
    .TOUCH_SENSE_IN(touch_in), .IRQ(IRQ));

  tks_osc_model i_tks_osc_model (
    .clk(CLK), .ref_run(ref_run), .key_run(key_run),
    .ref_tick(ref_tick), .key_tick(key_tick));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk

  // one ahb single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask : bus

  // module 0 only; start is dropped then raised, run length is counted
  task automatic measure(input logic [31:0] mc1, gctl, mask, output int len);
    bus(1'b1, `TKS_OFS_MC1_0, mc1, rd);
    bus(1'b1, `TKS_OFS_IMASK, mask, rd);
    bus(1'b1, `TKS_OFS_GCTL, 32'h0, rd);
    bus(1'b1, `TKS_OFS_GCTL, gctl, rd);
    len = 0;
    repeat (3) @(posedge CLK);
    chk(ref_run[0] === 1'b1 && key_run[0] === 1'b1, "osc idle in run");
    bus(1'b0, `TKS_OFS_GCTL, 32'h0, rd);
    chk(rd[`TKS_GC_SLOTFLG] === 1'b1, "slot flag low in run");
    while (ref_run[0] === 1'b1 && len < 5000) begin
      @(posedge CLK);
      len++;
    end
    repeat (3) @(posedge CLK);
    chk(ref_run === 3'h0 && key_run === 3'h0, "osc not stopped");
    chk(IRQ === mask[0], "irq level");
    bus(1'b0, `TKS_OFS_ISTAT, 32'h0, rd);
    chk(rd[`TKS_IS_DONE] === 1'b1, "done status missing");
  endtask : measure

  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // hang guard, runs take a few thousand cycles
  // ----------------------------------------
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge CLK);
    // pins come out of reset as plain I/O, so the pad enable follows the port logic
    chk(IRQ === 1'b0 && ref_run === 3'h0 && pad_oe === 12'hfff, "reset out");
    RESET <= 1'b0;
    @(posedge CLK);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0, rd);
      chk(rd === 32'h0, "reset value");
    end
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].wd, rd);
      bus(1'b0, rows[i].a, 32'h0, rd);
      chk(rd === rows[i].rd && HRESP === 1'b0, "readback");
      chk(touch_in === rows[i].t && gpio_in === ~rows[i].t, "pin use");
      chk(pad_oe === ~rows[i].t && pad_out === 12'ha5a, "pad drive");
    end
    // fast slot clock, unmasked
    measure(32'hbf, 32'h1, 32'h1, len_fast);
    @(posedge CLK);
    chk(IRQ === 1'b0, "irq kept after status read");
    bus(1'b0, `TKS_OFS_SENSE0, 32'h0, rd);
    chk(rd >= len_fast / 2 && rd <= len_fast / 2 + 12, "sense count");
    bus(1'b0, `TKS_OFS_CNT16, 32'h0, rd);
    chk(rd >= len_fast / 8 && rd <= len_fast / 8 + 6, "ref count");
    // reference slot clock, shared counter, masked
    measure(32'h3f, 32'h3, 32'h0, len_slow);
    chk(IRQ === 1'b0, "masked irq raised");
    chk(len_slow > len_fast * 3 / 2, "slot clock choice");
    // abort in mid run
    bus(1'b1, `TKS_OFS_IMASK, 32'h1, rd);
    // the last run left start high; drop it so the next write is a rising edge
    bus(1'b1, `TKS_OFS_GCTL, 32'h0, rd);
    bus(1'b1, `TKS_OFS_GCTL, 32'h1, rd);
    repeat (20) @(posedge CLK);
    chk(ref_run[0] === 1'b1, "abort run never started");
    bus(1'b1, `TKS_OFS_GCTL, 32'h0, rd);
    repeat (3) @(posedge CLK);
    chk(ref_run === 3'h0 && IRQ === 1'b0, "abort");
    report_and_stop();
  end
endmodule : testbench

// ---- tks_defs.svh ----
`ifndef TKS_DEFS_SVH
`define TKS_DEFS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TKS_OFS_MC1_0   8'h00
`define TKS_OFS_MC1_1   8'h04
`define TKS_OFS_MC1_2   8'h08
`define TKS_OFS_GCTL    8'h0c
`define TKS_OFS_PRESET  8'h10
`define TKS_OFS_SENSE0  8'h14
`define TKS_OFS_SENSE1  8'h18
`define TKS_OFS_SENSE2  8'h1c
`define TKS_OFS_CNT16   8'h20
`define TKS_OFS_ISTAT   8'h24
`define TKS_OFS_IMASK   8'h28
// ----------------------------------------------------------------
// field positions of the global control register
// ----------------------------------------------------------------
`define TKS_GC_START    0
`define TKS_GC_SHARED   1
`define TKS_GC_SENSEOV  4
`define TKS_GC_CNTOV    5
`define TKS_GC_SLOTFLG  6
// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define TKS_IS_DONE     0
`define TKS_IS_SENSEOV  1
`define TKS_IS_CNTOV    2
// ----------------------------------------------------------------
// counter limits and reset values
// ----------------------------------------------------------------
`define TKS_MAX8        8'hff
`define TKS_MAX5        5'h1f
`define TKS_MAX16       16'hffff
`define TKS_DIV_LAST    2'h3
`define TKS_MC1_RST     8'h00
`define TKS_MC1_MASK    8'hbf
`define TKS_NMOD        3
`endif

// ---- tks_osc_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// touch pad and oscillator model
// ----------------------------------------
module tks_osc_model #(
  parameter int REF_DIV = 8,  // cycles per reference tick
  parameter int KEY_DIV = 2   // cycles per key tick
) (
  // clock
  input  wire logic       clk,
  // run enables from the block
  input  wire logic [2:0] ref_run,
  input  wire logic [2:0] key_run,
  // one cycle ticks back to the block
  output logic      [2:0] ref_tick,
  output logic      [2:0] key_tick
);
  int cnt_q = 0;  // free phase count
  // ticks are registered so the run enable never loops back in one cycle
  always @(posedge clk) begin
    cnt_q <= cnt_q + 1;
    for (int m = 0; m < 3; m++) begin
      // a stopped oscillator stays silent
      ref_tick[m] <= ref_run[m] && (cnt_q % REF_DIV == 0);
      key_tick[m] <= key_run[m] && (cnt_q % KEY_DIV == 0);
    end
  end
endmodule : tks_osc_model

// ---- tks_pkg.sv ----
package tks_pkg;
  // per-module control byte, same layout as the register
  typedef struct packed {
    logic       slot_clock_select;   // 0 reference osc, 1 sys clock / 4
    logic       unused6;             // reads zero
    logic       reference_osc_enable;
    logic       key_osc_enable;
    logic [3:0] key_pin_select;      // bit0 key one .. bit3 key four
  } tks_mc1_s;

  // ahb address-phase capture
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } tks_ahb_s;

  // measurement sequencing
  typedef enum logic [1:0] {
    TKS_IDLE,
    TKS_RUN,
    TKS_DONE
  } tks_state_e;
endpackage : tks_pkg

// ---- tks_touch_scanner.sv ----
`timescale 1ns/1ps
`include "tks_defs.svh"
// Overview of operation
// - pin select 0 gives I/O, 1 touch
// - count sense ticks within divided reference slot
// - shared bit makes module 0 slot global
// - one common start launches all modules
// - start low clears counters, keeps 8-bit slot
// - start rising edge switches all counters on
// - 5-bit overflow stops oscillators and counters
// - slot clock is reference osc or sysclk/4
// - oscillators run only when enabled
// - interrupt on slot overflow of enabled modules
// - one interrupt; it clears all counters
// - sticky sense overflow flag, software clears
// - module 0 16-bit counter sticky overflow flag
// - three identical modules of four keys
// - software starts detection by raising start
// - slot flag high until slot overflow
// - slot select 0 reference, 1 sysclk/4
module tks_touch_scanner (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // oscillator ticks, one cycle pulses per module
  input  wire logic [2:0]  REF_OSC_TICK,
  input  wire logic [2:0]  KEY_OSC_TICK,
  // oscillator run enables per module
  output logic      [2:0]  REF_OSC_RUN,
  output logic      [2:0]  KEY_OSC_RUN,
  // key pads, twelve keys
  input  wire logic [11:0] PAD_IN,
  output logic      [11:0] PAD_OUT,
  output logic      [11:0] PAD_OE,
  // port logic side of the shared pins
  input  wire logic [11:0] GPIO_OUT,
  input  wire logic [11:0] GPIO_OE,
  output logic      [11:0] GPIO_IN,
  output logic      [11:0] TOUCH_SENSE_IN,
  // interrupt
  output logic             IRQ
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tks_pkg::tks_mc1_s   mc1_q [3];        // module control bytes
  logic [23:0]         preset_q;         // 8-bit slot presets, one byte each
  logic                start_q;          // start control bit
  logic                start_prev_q;     // start seen last cycle
  logic                shared_q;         // shared slot counter select
  logic                sense_ov_q;       // sticky sense overflow flag
  logic                cnt_ov_q;         // sticky module 0 counter flag
  logic [2:0]          istat_q;          // interrupt status
  logic [2:0]          imask_q;          // interrupt mask
  logic [1:0]          div_q;            // sysclk divide by four
  tks_pkg::tks_state_e state_q;          // measurement state
  logic [2:0]          done_q;           // module slot finished
  logic [15:0]         cnt16_q;          // module 0 16-bit counter
  logic [15:0]         cnt16_res_q;      // latched module 0 count
  logic [15:0]         sense_res_q [3];  // latched sense counts
  tks_pkg::tks_ahb_s   aph_q;            // captured address phase
  logic                aph_vld_q;        // data phase pending, read or write
  logic [31:0]         rdata_q;          // read data register
  logic [2:0]          run;              // module counting
  logic [2:0]          slot_ovf;         // own 5-bit overflow
  logic [2:0]          done_evt;         // module finishes this cycle
  logic [2:0]          sense_wrap;       // sense counter overflow
  logic [2:0]          active;           // module has enabled keys
  logic                start_rise;       // launch pulse
  logic                irq_evt;          // measurement complete
  logic                div_tick;         // one in four cycles
  logic                ahb_go;           // address phase accepted
  logic                wr_go;            // write data phase
  logic                rd_istat;         // status read, clears it
  logic [2:0]          istat_set;        // hardware events
  logic [31:0]         rdata_d;          // read mux
  logic                cnt16_wrap;       // module 0 counter overflow

  // ----------------------------------------------------------------
  // start edge and sequencing
  // ----------------------------------------------------------------
  // edge detection on the system clock: one launch per rising edge
  assign start_rise = start_q & ~start_prev_q;
  // previous start value
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_q;
    end
  end
  // divided system clock for the slot counter
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign div_tick = (div_q == `TKS_DIV_LAST);
  // a module counts only while started, measuring and not yet finished; gating on
  // start freezes the 8-bit slot counters in the very cycle that software drops it
  assign run = (state_q == tks_pkg::TKS_RUN && start_q) ? ~done_q : 3'h0;
  // interrupt when module 0 finishes (shared) or every enabled module has
  assign irq_evt = (state_q == tks_pkg::TKS_DONE);
  // measurement state machine
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= tks_pkg::TKS_IDLE;
    end else begin
      case (state_q)
        tks_pkg::TKS_IDLE: begin
          if (start_rise) begin
            state_q <= tks_pkg::TKS_RUN;
          end
        end
        tks_pkg::TKS_RUN: begin
          if (!start_q) begin
            state_q <= tks_pkg::TKS_IDLE;
          end else if (shared_q ? (done_q[0] | done_evt[0])
                                : (&((done_q | done_evt) | ~active))) begin
            state_q <= tks_pkg::TKS_DONE;
          end
        end
        tks_pkg::TKS_DONE: begin
          state_q <= tks_pkg::TKS_IDLE;
        end
        default: begin
          state_q <= tks_pkg::TKS_IDLE;
        end
      endcase
    end
  end
  // finished markers; a module finishing stops its oscillators
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      done_q <= 3'h0;
    end else if (state_q != tks_pkg::TKS_RUN) begin
      done_q <= 3'h0;
    end else begin
      done_q <= done_q | done_evt;
    end
  end

  // ----------------------------------------------------------------
  // per-module counters
  // ----------------------------------------------------------------
  genvar m;
  generate
    for (m = 0; m < `TKS_NMOD; m++) begin : g_mod
      logic [7:0]  slot8_q;   // programmable slot counter
      logic [4:0]  slot5_q;   // slot overflow counter
      logic [15:0] sense_q;   // sense oscillator cycle count
      logic        slot_tick; // slot clock for this module
      // module keeps enabled keys only if some pin is in touch mode
      assign active[m] = |mc1_q[m].key_pin_select;
      // slot clock source choice
      assign slot_tick = run[m] & (mc1_q[m].slot_clock_select ? div_tick
                       : (REF_OSC_TICK[m] & mc1_q[m].reference_osc_enable));
      assign slot_ovf[m] = slot_tick & (slot8_q == `TKS_MAX8)
                         & (slot5_q == `TKS_MAX5);
      // shared mode takes the module 0 slot as everyone's slot
      assign done_evt[m] = run[m] & (shared_q ? slot_ovf[0] : slot_ovf[m]);
      // 8+5 slot counter; the 8-bit part is not cleared by a stop
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          slot8_q <= 8'h00;
        end else if (irq_evt) begin
          slot8_q <= 8'h00;
        end else if (slot_tick) begin
          slot8_q <= (slot8_q == `TKS_MAX8) ? preset_q[8*m +: 8]
                                            : slot8_q + 8'h01;
        end
      end
      // 5-bit counter, cleared while start is low
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          slot5_q <= 5'h00;
        end else if (!start_q || irq_evt) begin
          slot5_q <= 5'h00;
        end else if (slot_tick && slot8_q == `TKS_MAX8) begin
          slot5_q <= slot5_q + 5'h01;
        end
      end
      // sense counter counts key oscillator cycles within the slot
      assign sense_wrap[m] = run[m] & mc1_q[m].key_osc_enable
                           & KEY_OSC_TICK[m] & (sense_q == `TKS_MAX16);
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          sense_q <= 16'h0000;
        end else if (!start_q || irq_evt) begin
          sense_q <= 16'h0000;
        end else if (run[m] && mc1_q[m].key_osc_enable && KEY_OSC_TICK[m]) begin
          sense_q <= sense_q + 16'h0001;
        end
      end
      // result latched before the interrupt clears the live counter
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          sense_res_q[m] <= 16'h0000;
        end else if (irq_evt) begin
          sense_res_q[m] <= sense_q;
        end
      end
      // oscillators run only when enabled and the slot is open
      assign REF_OSC_RUN[m] = run[m] & mc1_q[m].reference_osc_enable;
      assign KEY_OSC_RUN[m] = run[m] & mc1_q[m].key_osc_enable;
      // pin sharing: touch mode releases the pad driver
      for (genvar k = 0; k < 4; k++) begin : g_key
        assign PAD_OUT[4*m+k]        = GPIO_OUT[4*m+k];
        assign PAD_OE[4*m+k]         = ~mc1_q[m].key_pin_select[k] & GPIO_OE[4*m+k];
        assign GPIO_IN[4*m+k]        = ~mc1_q[m].key_pin_select[k] & PAD_IN[4*m+k];
        assign TOUCH_SENSE_IN[4*m+k] = mc1_q[m].key_pin_select[k] & PAD_IN[4*m+k];
      end
    end
  endgenerate

  // module 0 16-bit counter on the module 0 reference oscillator
  assign cnt16_wrap = run[0] & REF_OSC_TICK[0] & (cnt16_q == `TKS_MAX16);
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt16_q <= 16'h0000;
    end else if (!start_q || irq_evt) begin
      cnt16_q <= 16'h0000;
    end else if (run[0] && REF_OSC_TICK[0]) begin
      cnt16_q <= cnt16_q + 16'h0001;
    end
  end

  // latched module 0 count
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt16_res_q <= 16'h0000;
    end else if (irq_evt) begin
      cnt16_res_q <= cnt16_q;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait states, always okay; reads are prepared in the address phase
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign ahb_go    = HSEL & HTRANS[1] & HREADY;
  assign wr_go     = aph_vld_q & aph_q.wr;
  assign rd_istat  = ahb_go & ~HWRITE & (HADDR[7:0] == `TKS_OFS_ISTAT);
  assign HRDATA    = rdata_q;
  // address phase capture
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aph_vld_q <= 1'b0;
      aph_q     <= '0;
    end else begin
      aph_vld_q <= ahb_go;
      aph_q     <= '{wr: HWRITE, addr: HADDR[7:0]};
    end
  end
  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (HADDR[7:0])
      `TKS_OFS_MC1_0:  rdata_d[7:0] = mc1_q[0];
      `TKS_OFS_MC1_1:  rdata_d[7:0] = mc1_q[1];
      `TKS_OFS_MC1_2:  rdata_d[7:0] = mc1_q[2];
      `TKS_OFS_GCTL: begin
        rdata_d[`TKS_GC_START]   = start_q;
        rdata_d[`TKS_GC_SHARED]  = shared_q;
        rdata_d[`TKS_GC_SENSEOV] = sense_ov_q;
        rdata_d[`TKS_GC_CNTOV]   = cnt_ov_q;
        rdata_d[`TKS_GC_SLOTFLG] = (state_q == tks_pkg::TKS_RUN);
      end
      `TKS_OFS_PRESET: rdata_d[23:0] = preset_q;
      `TKS_OFS_SENSE0: rdata_d[15:0] = sense_res_q[0];
      `TKS_OFS_SENSE1: rdata_d[15:0] = sense_res_q[1];
      `TKS_OFS_SENSE2: rdata_d[15:0] = sense_res_q[2];
      `TKS_OFS_CNT16:  rdata_d[15:0] = cnt16_res_q;
      `TKS_OFS_ISTAT:  rdata_d[2:0]  = istat_q;
      `TKS_OFS_IMASK:  rdata_d[2:0]  = imask_q;
      default:         rdata_d       = 32'h0000_0000;
    endcase
  end
  // read data register, loaded only by an accepted read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= 32'h0000_0000;
    end else if (ahb_go && !HWRITE) begin
      rdata_q <= rdata_d;
    end
  end
  // module control bytes
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mc1_q[0] <= `TKS_MC1_RST;
      mc1_q[1] <= `TKS_MC1_RST;
      mc1_q[2] <= `TKS_MC1_RST;
    end else if (wr_go) begin
      if (aph_q.addr == `TKS_OFS_MC1_0) mc1_q[0] <= HWDATA[7:0] & `TKS_MC1_MASK;
      if (aph_q.addr == `TKS_OFS_MC1_1) mc1_q[1] <= HWDATA[7:0] & `TKS_MC1_MASK;
      if (aph_q.addr == `TKS_OFS_MC1_2) mc1_q[2] <= HWDATA[7:0] & `TKS_MC1_MASK;
    end
  end
  // slot presets and interrupt mask
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      preset_q <= 24'h000000;
      imask_q  <= 3'h0;
    end else if (wr_go) begin
      if (aph_q.addr == `TKS_OFS_PRESET) preset_q <= HWDATA[23:0];
      if (aph_q.addr == `TKS_OFS_IMASK)  imask_q  <= HWDATA[2:0];
    end
  end
  // global control: start, shared select
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      start_q  <= 1'b0;
      shared_q <= 1'b0;
    end else if (wr_go && aph_q.addr == `TKS_OFS_GCTL) begin
      start_q  <= HWDATA[`TKS_GC_START];
      shared_q <= HWDATA[`TKS_GC_SHARED];
    end
  end
  // sticky flags: hardware only sets, software writes 1 to clear; set wins
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sense_ov_q <= 1'b0;
      cnt_ov_q   <= 1'b0;
    end else begin
      sense_ov_q <= (|sense_wrap) | (sense_ov_q & ~(wr_go && aph_q.addr == `TKS_OFS_GCTL
                    && HWDATA[`TKS_GC_SENSEOV]));
      cnt_ov_q   <= cnt16_wrap | (cnt_ov_q & ~(wr_go && aph_q.addr == `TKS_OFS_GCTL
                    && HWDATA[`TKS_GC_CNTOV]));
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, read to clear, set wins
  // ----------------------------------------------------------------
  assign istat_set = {cnt16_wrap, |sense_wrap, irq_evt};
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      istat_q <= 3'h0;
    end else begin
      istat_q <= istat_set | (istat_q & {3{~rd_istat}});
    end
  end
  assign IRQ = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_launch_once: assert property (start_rise && state_q == tks_pkg::TKS_IDLE
    |=> state_q == tks_pkg::TKS_RUN ##1 !start_rise)
    else $error("start edge did not launch once");
  a_stop_clears: assert property (!start_q |=> g_mod[0].sense_q == 16'h0000
    && g_mod[0].slot5_q == 5'h00 && cnt16_q == 16'h0000)
    else $error("counters not cleared while stopped");
  a_slot8_kept: assert property (!start_q && !irq_evt |=> $stable(g_mod[1].slot8_q))
    else $error("8-bit slot counter changed while stopped");
  a_ovf_stops: assert property (done_evt[0] |=> !REF_OSC_RUN[0] && !KEY_OSC_RUN[0])
    else $error("oscillators still run after slot overflow");
  a_osc_gated: assert property (KEY_OSC_RUN[2] |-> mc1_q[2].key_osc_enable
    && state_q == tks_pkg::TKS_RUN)
    else $error("key oscillator runs while disabled");
  a_shared_irq: assert property (shared_q && start_q && state_q == tks_pkg::TKS_RUN
    && done_evt[0] |=> irq_evt)
    else $error("shared slot overflow gave no interrupt");
  a_irq_clears: assert property (irq_evt |=> g_mod[2].slot8_q == 8'h00
    && g_mod[2].sense_q == 16'h0000 && istat_q[`TKS_IS_DONE])
    else $error("interrupt did not clear counters");
  a_sense_sticky: assert property (|sense_wrap |=> sense_ov_q)
    else $error("sense overflow flag not set");
  a_cnt_sticky: assert property (cnt_ov_q && !wr_go |=> cnt_ov_q)
    else $error("counter overflow flag cleared by hardware");
  a_pin_touch: assert property (mc1_q[0].key_pin_select[0] |-> !PAD_OE[0] && !GPIO_IN[0])
    else $error("touch pin still driven as I/O");
  a_irq_level: assert property (istat_q[`TKS_IS_DONE] && imask_q[`TKS_IS_DONE] |-> IRQ)
    else $error("unmasked status gave no interrupt");

  c_measure_done: cover property (done_evt[0] ##1 irq_evt);
  c_shared_mode: cover property (shared_q && irq_evt);
  c_sense_wrap: cover property (|sense_wrap);
  c_status_read: cover property (istat_q[`TKS_IS_DONE] ##1 rd_istat);
endmodule : tks_touch_scanner
